/* File: dtcc_regs.svh */
// Purpose: Offsets, fields and reset values of the timer count control
// Assumes: 16-bit byte address space, 8-bit registers
// Notes:   Included by the design file only
`ifndef DTCC_REGS_SVH
`define DTCC_REGS_SVH

`define DTCC_TIMER0_CTL_ADDR  16'hFF7E
`define DTCC_TIMER1_CTL_ADDR  16'hFF94
`define DTCC_CTL_RESET        8'h00
`define DTCC_CTL_WRITE_MASK   8'h87
`define DTCC_RUN_BIT          7
`define DTCC_SEL_MSB          2
`define DTCC_SEL_LSB          0
`define DTCC_PRESCALE_WIDTH   7
`define DTCC_COUNT_WIDTH      16

`endif

/* File: dtcc_pkg.sv */
// Purpose: Types shared by the timer count control block
// Assumes: Nothing beyond the register header
// Notes:   Mode encoding of the second timer's sync field
package dtcc_pkg;

    typedef enum logic [1:0] {
        DTCC_MODE_INDEP      = 2'h0,
        DTCC_MODE_SYNC_START = 2'h1,
        DTCC_MODE_SYNC_CLEAR = 2'h2,
        DTCC_MODE_PROHIBITED = 2'h3
    } dtcc_mode_e;

    typedef logic [2:0] dtcc_sel_t;

endpackage

/* File: dtcc_top.sv */
// Purpose: Run control and count clock selection for two 16-bit timers
// Assumes: clk is the peripheral clock (20 MHz); PLL clock comes as a tick
// Notes:   Byte and single-bit writes; reads answer one cycle later
//
// Notes on behaviour
// - Run bit 0 stops and clears the counter; 1 counts on selected clock.
// - PLL select 1: 000 picks PLL timer clock, 001 peripheral clock.
// - Reset clears both control registers; bit or byte writes allowed.
// - Run at bit 7, selector bits 2..0, bits 6..3 read zero.
// - Second timer mode: 10 uses timer 0's clock select; 00, 01 and 11 use its own.
`timescale 1ns/1ps
`include "dtcc_regs.svh"

module dtcc_top (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [15:0] busAddr,
    input  wire logic        busWrite,
    input  wire logic [7:0]  busWrData,
    input  wire logic        busBitWrite,
    input  wire logic [2:0]  busBitPos,
    input  wire logic        busBitVal,
    input  wire logic        busRead,
    output logic      [7:0]  busRdData,
    input  wire logic        pllSelectBit,
    input  wire logic        pllTimerTick,
    input  wire logic        syncModeBit1,
    input  wire logic        syncModeBit0,
    output logic      [15:0] timer0Count,
    output logic      [15:0] timer1Count,
    output logic             timer0RunBit,
    output logic             timer1RunBit
);

    logic                             rstSync1_r;
    logic                             rstSyncN_r;
    logic [7:0]                       ctl_r [2];
    logic [`DTCC_PRESCALE_WIDTH-1:0]  prescale_r;
    logic [`DTCC_COUNT_WIDTH-1:0]     count_r [2];
    logic [7:0]                       rdData_r;
    logic [1:0]                       tick;
    dtcc_pkg::dtcc_sel_t              effSel [2];
    dtcc_pkg::dtcc_mode_e             mode;

    // Two-flop reset release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstSync1_r <= 1'b0;
            rstSyncN_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSyncN_r <= rstSync1_r;
        end
    end

    // Address decode, 0 when unmapped
    function automatic logic [1:0] decodeAddr(input logic [15:0] a);
        if (a == `DTCC_TIMER0_CTL_ADDR) begin
            decodeAddr = 2'h1;
        end else if (a == `DTCC_TIMER1_CTL_ADDR) begin
            decodeAddr = 2'h2;
        end else begin
            decodeAddr = 2'h0;
        end
    endfunction

    // Count tick from selector, PLL select and prescaler
    function automatic logic selectTick(
        input dtcc_pkg::dtcc_sel_t        sel,
        input logic                       pll,
        input logic [`DTCC_PRESCALE_WIDTH-1:0] pre,
        input logic                       pllTick
    );
        logic [`DTCC_PRESCALE_WIDTH-1:0] mask;
        mask = `DTCC_PRESCALE_WIDTH'((8'h01 << sel) - 8'h01);
        if (!pll) begin
            selectTick = ((pre & mask) == mask);
        end else if (sel == 3'h0) begin
            selectTick = pllTick;
        end else if (sel == 3'h1) begin
            selectTick = 1'b1;
        end else begin
            selectTick = 1'b0;
        end
    endfunction

    assign mode = dtcc_pkg::dtcc_mode_e'({syncModeBit1, syncModeBit0});

    always_comb begin
        effSel[0] = ctl_r[0][`DTCC_SEL_MSB:`DTCC_SEL_LSB];
        case (mode)
            dtcc_pkg::DTCC_MODE_SYNC_CLEAR:
                effSel[1] = ctl_r[0][`DTCC_SEL_MSB:`DTCC_SEL_LSB];
            dtcc_pkg::DTCC_MODE_INDEP,
            dtcc_pkg::DTCC_MODE_SYNC_START:
                effSel[1] = ctl_r[1][`DTCC_SEL_MSB:`DTCC_SEL_LSB];
            default:
                effSel[1] = ctl_r[1][`DTCC_SEL_MSB:`DTCC_SEL_LSB];
        endcase
    end

    // Free-running prescaler on the peripheral clock
    always_ff @(posedge clk or negedge rstSyncN_r) begin
        if (!rstSyncN_r) begin
            prescale_r <= '0;
        end else begin
            prescale_r <= prescale_r + `DTCC_PRESCALE_WIDTH'(1);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gTimer
            logic [7:0] nxt;
            always_comb begin
                nxt = ctl_r[gi];
                if (busWrite && decodeAddr(busAddr) == 2'(gi + 1)) begin
                    nxt = busWrData;
                end else if (busBitWrite
                             && decodeAddr(busAddr) == 2'(gi + 1)) begin
                    nxt[busBitPos] = busBitVal;
                end
            end

            // Control register; fixed bits forced to zero
            always_ff @(posedge clk or negedge rstSyncN_r) begin
                if (!rstSyncN_r) begin
                    ctl_r[gi] <= `DTCC_CTL_RESET;
                end else begin
                    ctl_r[gi] <= nxt & `DTCC_CTL_WRITE_MASK;
                end
            end

            assign tick[gi] = selectTick(effSel[gi], pllSelectBit,
                                         prescale_r, pllTimerTick);

            // Counter: held at zero while stopped
            always_ff @(posedge clk or negedge rstSyncN_r) begin
                if (!rstSyncN_r) begin
                    count_r[gi] <= '0;
                end else if (!ctl_r[gi][`DTCC_RUN_BIT]) begin
                    count_r[gi] <= '0;
                end else if (tick[gi]) begin
                    count_r[gi] <= count_r[gi]
                                   + `DTCC_COUNT_WIDTH'(1);
                end
            end
        end
    endgenerate

    // Registered read answer, zero when unmapped
    always_ff @(posedge clk or negedge rstSyncN_r) begin
        if (!rstSyncN_r) begin
            rdData_r <= 8'h00;
        end else if (busRead) begin
            case (decodeAddr(busAddr))
                2'h1:    rdData_r <= ctl_r[0];
                2'h2:    rdData_r <= ctl_r[1];
                default: rdData_r <= 8'h00;
            endcase
        end
    end

    assign busRdData    = rdData_r;
    assign timer0Count  = count_r[0];
    assign timer1Count  = count_r[1];
    assign timer0RunBit = ctl_r[0][`DTCC_RUN_BIT];
    assign timer1RunBit = ctl_r[1][`DTCC_RUN_BIT];

endmodule // dtcc_top

/* File: dtcc_top_sva.sv */
// Purpose: Port assertions for dtcc_top
// Assumes: One clock domain, reset on rstn
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
module dtcc_top_chk (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [15:0] busAddr,
    input wire logic        busWrite,
    input wire logic [7:0]  busWrData,
    input wire logic        busBitWrite,
    input wire logic [2:0]  busBitPos,
    input wire logic        busBitVal,
    input wire logic        busRead,
    input wire logic [7:0]  busRdData,
    input wire logic        syncModeBit1,
    input wire logic        syncModeBit0,
    input wire logic [15:0] timer0Count,
    input wire logic [15:0] timer1Count,
    input wire logic        timer0RunBit,
    input wire logic        timer1RunBit
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_stop_clear: assert property (!timer0RunBit |=> timer0Count == 16'h0)
        else $error("stopped count not zero");
    a_step_one: assert property ($past(timer0RunBit) && timer0RunBit
        |-> timer0Count - $past(timer0Count) <= 16'h1) else $error("step");
    a_run_write: assert property (busWrite && busAddr == 16'hFF7E
        |=> timer0RunBit == $past(busWrData[7])) else $error("byte write");
    a_bit_write: assert property (busBitWrite && !busWrite &&
        busAddr == 16'hFF94 && busBitPos == 3'h7
        |=> timer1RunBit == $past(busBitVal)) else $error("bit write");
    a_read_mask: assert property (busRead |=> busRdData[6:3] == 4'h0)
        else $error("fixed bits set");
    a_unmapped_read: assert property (busRead && busAddr != 16'hFF7E &&
        busAddr != 16'hFF94 |=> busRdData == 8'h00) else $error("unmapped");
    a_mode_clear: assert property (syncModeBit1 && !syncModeBit0 &&
        $stable({syncModeBit1, syncModeBit0}) && timer0RunBit && timer1RunBit
        && $past(timer0RunBit && timer1RunBit)
        |-> $changed(timer0Count) == $changed(timer1Count)) else $error("mode");
    c_mode: cover property (syncModeBit1 && timer1Count != 16'h0);
    c_unmapped: cover property (busRead && busAddr == 16'hFF7F);
    c_bit: cover property (busBitWrite && busBitPos == 3'h1);
endmodule // dtcc_top_chk
bind dtcc_top dtcc_top_chk chk (.*);

/* File: test_dtcc_top.sv */
// Purpose: Self-checking bench for dtcc_top
// Assumes: Inputs driven 2 ns after the rising edge
// Notes:   Count rates compared within two ticks
`timescale 1ns/1ps
module test_dtcc_top;
    logic        clk, rstn, busWrite, busBitWrite, busBitVal, busRead;
    logic        pllSelectBit, pllTimerTick, syncModeBit1, syncModeBit0;
    logic        timer0RunBit, timer1RunBit;
    logic [2:0]  busBitPos;
    logic [7:0]  busWrData, busRdData, d;
    logic [15:0] busAddr, timer0Count, timer1Count;
    logic [15:0] ad [3] = '{16'hFF7E, 16'hFF94, 16'hFF7F};
    logic [7:0]  mk [3] = '{8'h87, 8'h87, 8'h00};
    int          error_cnt = 0, compares = 0, n, tk;
    dtcc_top dut (
        .clk          (clk),
        .rstn         (rstn),
        .busAddr      (busAddr),
        .busWrite     (busWrite),
        .busWrData    (busWrData),
        .busBitWrite  (busBitWrite),
        .busBitPos    (busBitPos),
        .busBitVal    (busBitVal),
        .busRead      (busRead),
        .busRdData    (busRdData),
        .pllSelectBit (pllSelectBit),
        .pllTimerTick (pllTimerTick),
        .syncModeBit1 (syncModeBit1),
        .syncModeBit0 (syncModeBit0),
        .timer0Count  (timer0Count),
        .timer1Count  (timer1Count),
        .timer0RunBit (timer0RunBit),
        .timer1RunBit (timer1RunBit)
    );
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    task automatic cyc(input int c = 1);
        repeat (c) @(posedge clk);
        #2;
    endtask
    task automatic chk(input string s, input int e, input logic [15:0] g,
                       input int t);
        compares++;
        if ($isunknown(g) || int'(g) > e + t || int'(g) < e - t) begin
            error_cnt++;
            $display("unexpected %s exp %0d got %0d", s, e, g);
        end
    endtask
    // Kind 0 byte write, 1 bit write (pos v[2:0], value v[3]), 2 read
    task automatic acc(input int k, input logic [15:0] a, input logic [7:0] v);
        cyc();
        busAddr = a;
        busWrData = v;
        {busBitVal, busBitPos} = v[3:0];
        {busWrite, busBitWrite, busRead} = {k == 0, k == 1, k == 2};
        cyc();
        {busWrite, busBitWrite, busRead} = 3'h0;
    endtask
    function automatic int model(input logic [2:0] s, input int w);
        if (!pllSelectBit)
            return w >> s;
        return s == 3'h0 ? tk : (s == 3'h1 ? w : 0);
    endfunction
    task automatic run(input logic [2:0] s0, s1, input logic [1:0] m);
        {syncModeBit1, syncModeBit0} = m;
        acc(0, 16'hFF7E, {5'h00, s0});
        acc(0, 16'hFF94, {5'h00, s1});
        acc(0, 16'hFF7E, {5'h10, s0});
        acc(0, 16'hFF94, {5'h10, s1});
        chk("run0", 1, timer0RunBit, 0);
        chk("run1", 1, timer1RunBit, 0);
        n = 64 * (1 + $urandom % 4);
        tk = 0;
        repeat (n) begin
            pllTimerTick = 1'($urandom % 2);
            tk += pllTimerTick;
            cyc();
        end
        pllTimerTick = 1'h0;
        chk("count0", model(s0, n + 2), timer0Count, 2);
        chk("count1", model(m == 2'h2 ? s0 : s1, n), timer1Count, 2);
        acc(1, 16'hFF7E, 8'h07);
        acc(1, 16'hFF94, 8'h07);
        cyc();
        chk("runoff0", 0, timer0RunBit, 0);
        chk("runoff1", 0, timer1RunBit, 0);
        chk("stop0", 0, timer0Count, 0);
        chk("stop1", 0, timer1Count, 0);
    endtask
    task automatic end_of_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        {rstn, busWrite, busBitWrite, busRead, busBitVal} = 5'h00;
        {pllSelectBit, pllTimerTick, syncModeBit1, syncModeBit0} = 4'h0;
        {busAddr, busWrData, busBitPos} = 27'h0;
        void'($urandom(36));
        repeat (6) @(posedge clk);
        #2 rstn = 1'h1;
        cyc(3);
        for (int i = 0; i < 3; i++) begin
            acc(2, ad[i], 8'h00);
            chk("reset", 0, busRdData, 0);
            d = {1'h0, 7'($urandom)};
            acc(0, ad[i], d);
            acc(1, ad[i], 8'h09);
            acc(2, ad[i], 8'h00);
            chk("read", (d | 8'h02) & mk[i], busRdData, 0);
        end
        for (int k = 0; k < 8; k++)
            run(3'(k), 3'(7 - k), 2'h0);
        for (int m = 1; m < 4; m++)
            run(3'h3, 3'h0, 2'(m));
        pllSelectBit = 1'h1;
        for (int k = 0; k < 3; k++)
            run(3'(k), 3'(k + 3), 2'h0);
        end_of_test;
    end
endmodule // test_dtcc_top
